/* File: common/stc_pkg.sv */
// package: register map, field layout and reset values of the secondary time base control
package stc_pkg;
    localparam logic [7:0]  STC_OFS_CTRL       = 8'h00;
    localparam logic [7:0]  STC_OFS_PERIOD     = 8'h04;
    localparam logic [7:0]  STC_OFS_ACT_PERIOD = 8'h08;
    localparam logic [7:0]  STC_OFS_STATUS     = 8'h0c;
    localparam logic [7:0]  STC_OFS_MASK       = 8'h10;

    localparam int          STC_POS_PENDING  = 12;
    localparam int          STC_POS_IRQ_EN   = 11;
    localparam int          STC_POS_IMM_UPD  = 10;
    localparam int          STC_POS_POL_INV  = 9;
    localparam int          STC_POS_SYNC_OE  = 8;
    localparam int          STC_POS_SYNC_EN  = 7;
    localparam int          STC_POS_SRC_LO   = 4;
    localparam int          STC_POS_PS_LO    = 0;

    localparam logic [11:0] STC_CTRL_WR_MASK = 12'hfff;
    localparam logic [15:0] STC_CTRL_RESET   = 16'h0000;
    localparam logic [15:0] STC_PERIOD_RESET = 16'hffff;
    localparam logic [2:0]  STC_STAT_RESET   = 3'h0;

    localparam int          STC_ST_EVENT  = 0;
    localparam int          STC_ST_SYNC   = 1;
    localparam int          STC_ST_RELOAD = 2;

    localparam logic [2:0]  STC_SRC_ONE = 3'h0;
    localparam logic [2:0]  STC_SRC_TWO = 3'h1;
endpackage

/* File: common/stc_ps_if.sv */
// interface: compare match, postscale code and trigger between control and postscaler
`timescale 1ns/1ps
interface stc_ps_if;
    logic       match;
    logic [3:0] code;
    logic       trigger;
    modport ctl (output match, output code, input trigger);
    modport ps  (input match, input code, output trigger);
endinterface

/* File: core/stc_postscale.sv */
// postscaler: divides special event compare matches into triggers
`timescale 1ns/1ps
module stc_postscale
    import stc_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    stc_ps_if.ps      bus
);
    logic [3:0] cnt_r;
    logic       trig_r;

    assign bus.trigger = trig_r;

    // a count already past a lowered code fires on the next match rather than wrapping
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_r <= 4'h0;
        end else if (bus.match) begin
            cnt_r <= (cnt_r >= bus.code) ? 4'h0 : cnt_r + 4'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            trig_r <= 1'b0;
        end else begin
            trig_r <= bus.match && (cnt_r >= bus.code);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_PS_EVERY: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (bus.match && bus.code == 4'h0) |=> trig_r)
        else $error("code zero did not trigger on a match");
    AST_PS_DIV: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (bus.match && cnt_r < bus.code) |=> !trig_r)
        else $error("trigger before the postscale count was reached");
    COV_PS_TWO: cover property (@(posedge sys_clk) disable iff (!rst_n)
        bus.code == 4'h1 && trig_r);
endmodule

/* File: core/stc_top.sv */
// secondary time base control: registers, period update, sync in/out, special event interrupt
// What this block does
// - special event sets a pending flag; software clears it by writing one to status; interrupt gated by enable bit.
// - immediate update bit applies new period now, otherwise at cycle boundary.
// - polarity bit inverts sync inputs and sync output; output driven only when enabled.
// - source code 000 selects input one, 001 input two; sync only when enabled.
// - postscale code n triggers every n+1 compare matches, up to sixteen.
// - postscale code 0000 triggers on every compare match.
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module stc_top
    import stc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        cycle_boundary,
    input  wire logic        compare_match,
    input  wire logic        sync_input_one,
    input  wire logic        sync_input_two,
    output logic             sync_output_two,
    output logic             sync_output_two_oe,
    output logic      [15:0] active_period,
    output logic             period_load,
    output logic             ext_sync_reset,
    output logic             special_event_trigger,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////
    // register bus slave
    logic        ack_r;
    logic [31:0] readdata_r;
    logic [15:0] ctrl_r;
    logic [15:0] period_shadow_r;
    logic [15:0] active_period_r;
    logic        reload_pend_r;
    logic [2:0]  status_r;
    logic [2:0]  mask_r;
    logic        wr_go;
    logic [15:0] wmask;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction

    // one wait cycle: read data are registered on the first edge, taken on the second
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    assign wr_go           = avs_write && ack_r;
    assign wmask           = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign avs_readdata    = readdata_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read || avs_write) && !ack_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            readdata_r <= 32'h0000_0000;
        end else if (avs_read && !ack_r) begin
            readdata_r <= 32'h0000_0000;
            if (hit(avs_address, STC_OFS_CTRL)) begin
                readdata_r[15:0] <= {3'h0, status_r[STC_ST_EVENT], ctrl_r[11:0]};
            end else if (hit(avs_address, STC_OFS_PERIOD)) begin
                readdata_r[15:0] <= period_shadow_r;
            end else if (hit(avs_address, STC_OFS_ACT_PERIOD)) begin
                readdata_r[15:0] <= active_period_r;
            end else if (hit(avs_address, STC_OFS_STATUS)) begin
                readdata_r[2:0] <= status_r;
            end else if (hit(avs_address, STC_OFS_MASK)) begin
                readdata_r[2:0] <= mask_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register; bits 15..13 and the pending bit are never stored from the bus
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_r <= STC_CTRL_RESET;
        end else if (wr_go && hit(avs_address, STC_OFS_CTRL)) begin
            ctrl_r <= {4'h0, (ctrl_r[11:0] & ~(wmask[11:0] & STC_CTRL_WR_MASK))
                             | (avs_writedata[11:0] & wmask[11:0] & STC_CTRL_WR_MASK)};
        end
    end

    logic       irq_en;
    logic       imm_upd;
    logic       pol_inv;
    logic       sync_oe;
    logic       sync_en;
    logic [2:0] sync_src;

    assign irq_en   = ctrl_r[STC_POS_IRQ_EN];
    assign imm_upd  = ctrl_r[STC_POS_IMM_UPD];
    assign pol_inv  = ctrl_r[STC_POS_POL_INV];
    assign sync_oe  = ctrl_r[STC_POS_SYNC_OE];
    assign sync_en  = ctrl_r[STC_POS_SYNC_EN];
    assign sync_src = ctrl_r[STC_POS_SRC_LO +: 3];

    ////////////////////////////////////////////////////////////////////////
    // period shadow and active period
    logic period_wr;
    assign period_wr = wr_go && hit(avs_address, STC_OFS_PERIOD);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            period_shadow_r <= STC_PERIOD_RESET;
        end else if (period_wr) begin
            period_shadow_r <= (period_shadow_r & ~wmask) | (avs_writedata[15:0] & wmask);
        end
    end

    // a deferred value waits for the counter's own boundary so a running period is never cut short
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            active_period_r <= STC_PERIOD_RESET;
            reload_pend_r   <= 1'b0;
        end else if (period_wr && imm_upd) begin
            active_period_r <= (period_shadow_r & ~wmask) | (avs_writedata[15:0] & wmask);
            reload_pend_r   <= 1'b0;
        end else if (period_wr) begin
            reload_pend_r <= 1'b1;
        end else if (cycle_boundary && reload_pend_r) begin
            active_period_r <= period_shadow_r;
            reload_pend_r   <= 1'b0;
        end
    end

    logic load_r;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            load_r <= 1'b0;
        end else begin
            load_r <= (period_wr && imm_upd) || (!period_wr && cycle_boundary && reload_pend_r);
        end
    end
    assign active_period = active_period_r;
    assign period_load   = load_r;

    ////////////////////////////////////////////////////////////////////////
    // sync inputs: two flops, polarity, source select, edge detect
    logic [1:0] sync_s1_r;
    logic [1:0] sync_s2_r;
    logic       sync_prev_r;
    logic       sync_sel;
    logic       sync_valid;
    logic       sync_pulse_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync_s1_r <= 2'h0;
            sync_s2_r <= 2'h0;
        end else begin
            sync_s1_r <= {sync_input_two, sync_input_one};
            sync_s2_r <= sync_s1_r;
        end
    end

    // reserved source codes select nothing, so no sync can fire from them
    always_comb begin
        sync_valid = 1'b1;
        unique case (sync_src)
            STC_SRC_ONE: sync_sel = sync_s2_r[0] ^ pol_inv;
            STC_SRC_TWO: sync_sel = sync_s2_r[1] ^ pol_inv;
            default: begin
                sync_sel   = 1'b0;
                sync_valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync_prev_r  <= 1'b0;
            sync_pulse_r <= 1'b0;
        end else begin
            sync_prev_r  <= sync_sel;
            sync_pulse_r <= sync_en && sync_valid && sync_sel && !sync_prev_r;
        end
    end
    assign ext_sync_reset = sync_pulse_r;

    ////////////////////////////////////////////////////////////////////////
    // sync output: one-cycle pulse at each period boundary, polarity applied
    logic sync_out_r;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync_out_r <= 1'b0;
        end else begin
            sync_out_r <= cycle_boundary ^ pol_inv;
        end
    end
    assign sync_output_two    = sync_oe ? sync_out_r : 1'b0;
    assign sync_output_two_oe = sync_oe;

    ////////////////////////////////////////////////////////////////////////
    // postscaler
    stc_ps_if ps_bus();
    assign ps_bus.match   = compare_match;
    assign ps_bus.code    = ctrl_r[STC_POS_PS_LO +: 4];
    assign special_event_trigger = ps_bus.trigger;

    stc_postscale u_ps (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .bus     (ps_bus.ps)
    );

    ////////////////////////////////////////////////////////////////////////
    // sticky status, write one to clear; a new event wins over a clear in the same cycle
    logic [2:0] st_set;
    logic [2:0] st_clr;
    assign st_set = {load_r, sync_pulse_r, ps_bus.trigger};
    assign st_clr = (wr_go && hit(avs_address, STC_OFS_STATUS) && avs_byteenable[0])
                    ? avs_writedata[2:0] : 3'h0;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            status_r <= STC_STAT_RESET;
        end else begin
            status_r <= st_set | (status_r & ~st_clr);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mask_r <= STC_STAT_RESET;
        end else if (wr_go && hit(avs_address, STC_OFS_MASK) && avs_byteenable[0]) begin
            mask_r <= avs_writedata[2:0];
        end
    end

    // the special event line also needs its own enable bit
    assign irq = |(status_r & mask_r & {2'b11, irq_en});

    ////////////////////////////////////////////////////////////////////////
    // checks
    AST_PEND_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ps_bus.trigger |=> status_r[STC_ST_EVENT] ##1 (status_r[STC_ST_EVENT] || $past(st_clr[STC_ST_EVENT])))
        else $error("pending flag lost after special event");
    AST_IRQ_GATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!irq_en && (status_r[2:1] & mask_r[2:1]) == 2'h0) |-> !irq)
        else $error("interrupt raised while special event irq disabled");
    AST_IMM_UPD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (period_wr && imm_upd && avs_byteenable[1:0] == 2'h3) |=>
        (active_period_r == $past(avs_writedata[15:0]) && load_r))
        else $error("immediate period update not applied");
    AST_DEFER_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!(period_wr && imm_upd) && !cycle_boundary) |=> $stable(active_period_r))
        else $error("active period changed away from a cycle boundary");
    AST_SYNC_OUT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cycle_boundary && sync_oe && !pol_inv) ##1 sync_oe |-> sync_output_two)
        else $error("sync output missing at boundary");
    AST_SYNC_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !sync_oe |-> (!sync_output_two && !sync_output_two_oe))
        else $error("sync output driven while disabled");
    AST_SYNC_SRC: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sync_src > STC_SRC_TWO || !sync_en) |=> !sync_pulse_r)
        else $error("external sync from reserved source or while disabled");
    AST_SYNC_EDGE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sync_en && sync_src == STC_SRC_ONE && !pol_inv && $rose(sync_s2_r[0])
         && $stable(ctrl_r)) |=> sync_pulse_r)
        else $error("selected sync input edge not forwarded");
    AST_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (avs_read && !avs_waitrequest) |-> avs_readdata[31:16] == 16'h0000 &&
        (!hit(avs_address, STC_OFS_CTRL) || avs_readdata[15:13] == 3'h0))
        else $error("unimplemented control bits read nonzero");
    AST_BUS_ONE_WAIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after exactly one wait cycle");

    COV_TRIG_IRQ: cover property (@(posedge sys_clk) disable iff (!rst_n) ps_bus.trigger ##1 irq);
    COV_EXT_SYNC: cover property (@(posedge sys_clk) disable iff (!rst_n) sync_pulse_r);
    COV_DEFER:    cover property (@(posedge sys_clk) disable iff (!rst_n)
        cycle_boundary && reload_pend_r);
    COV_IMM:      cover property (@(posedge sys_clk) disable iff (!rst_n) period_wr && imm_upd);
endmodule

/* File: dv/stc_far_model.sv */
// far-side model: period counter events and external sync pins
`timescale 1ns/1ps
module stc_far_model (
    input  wire logic sys_clk,
    input  wire logic pol_inv,
    output logic      cycle_boundary,
    output logic      compare_match,
    output logic      sync_input_one,
    output logic      sync_input_two
);
    logic [3:0] ev = 4'h0;

    assign cycle_boundary = ev[0];
    assign compare_match  = ev[1];
    // pins idle at the inactive level, so an inverted setup idles high
    assign sync_input_one = ev[2] ^ pol_inv;
    assign sync_input_two = ev[3] ^ pol_inv;

    // one-cycle event: 0 boundary, 1 match, 2 pin one, 3 pin two
    task automatic fire(input int kind);
        @(posedge sys_clk);
        ev[kind] <= 1'b1;
        @(posedge sys_clk);
        ev[kind] <= 1'b0;
    endtask
endmodule

/* File: dv/test_secondary_timebase_control.sv */
// testbench: register bus, postscaler, period update, sync and interrupt checks
`timescale 1ns/1ps
module test_secondary_timebase_control;
    import stc_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h3;
    logic [3:0]  be_sel = 4'h3;
    logic [31:0] n_load = 0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        far_pol = 1'b0;
    logic        cyc_b, cmp_m, sin1, sin2, sout, sout_oe, pload, ext_rst, trig, irq;
    logic [15:0] act_per, ctl, per;
    logic [31:0] n_trig = 0, n_ext = 0, n_out = 0, b_trig, b_ext, b_out;
    logic [15:0] exp_q[$];
    logic [3:0]  ps [4] = '{4'h0, 4'h1, 4'hf, 4'h0};
    logic [15:0] sy [4] = '{16'h0180, 16'h0390, 16'h00a0, 16'h0000};
    logic [31:0] sy_ext [4] = '{32'd1, 32'd1, 32'd0, 32'd0};
    int          n_fail = 0;
    int          checks_done = 0;
    int          seed_val;

    always #20 sys_clk = ~sys_clk;

    stc_far_model u_far (.sys_clk(sys_clk), .pol_inv(far_pol), .cycle_boundary(cyc_b),
                         .compare_match(cmp_m), .sync_input_one(sin1), .sync_input_two(sin2));

    stc_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
                   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
                   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
                   .cycle_boundary(cyc_b), .compare_match(cmp_m), .sync_input_one(sin1),
                   .sync_input_two(sin2), .sync_output_two(sout), .sync_output_two_oe(sout_oe),
                   .active_period(act_per), .period_load(pload), .ext_sync_reset(ext_rst),
                   .special_event_trigger(trig), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // request held until waitrequest is sampled low at a rising edge, released right after that edge
    task automatic bus(input logic wr_en, input logic [7:0] a, input logic [15:0] d);
        int n;
        @(posedge sys_clk);
        avs_address    <= a;
        avs_writedata  <= {16'h0, d};
        avs_byteenable <= be_sel;
        avs_write      <= wr_en;
        avs_read       <= ~wr_en;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            n_fail++;
            finish_test();
        end
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 16'h0);
    endtask

    task automatic snap();
        b_trig = n_trig;
        b_ext  = n_ext;
        b_out  = n_out;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // result watcher: read data against the oldest note, pulses counted
    always @(posedge sys_clk) begin
        if (rst_n) begin
            n_trig <= n_trig + 32'(trig);
            n_ext  <= n_ext + 32'(ext_rst);
            n_out  <= n_out + 32'(sout ^ far_pol);
            n_load <= n_load + 32'(pload);
        end
        if (avs_read && avs_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("wrong value at %0t ns: read with no expectation", $time);
            end
            else check(avs_readdata, {16'h0, exp_q.pop_front()});
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        finish_test();
    end

    initial begin
        seed_val = $urandom(32'hd548);
        ps[3] = 4'($urandom);
        per = 16'($urandom) & 16'hfff8;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(STC_OFS_CTRL, STC_CTRL_RESET);
        rd(STC_OFS_ACT_PERIOD, STC_PERIOD_RESET);
        rd(8'h14, 16'h0000);
        bus(1'b1, STC_OFS_CTRL, 16'hffff);
        rd(STC_OFS_CTRL, 16'h0fff);
        bus(1'b1, STC_OFS_MASK, 16'h0001);
        // each burst is a whole number of periods, so the divider restarts at zero
        for (int i = 0; i < 4; i++) begin
            ctl = 16'h0800 | 16'(ps[i]);
            bus(1'b1, STC_OFS_CTRL, ctl);
            snap();
            repeat (2 * (int'(ps[i]) + 1)) u_far.fire(1);
            repeat (3) @(posedge sys_clk);
            check(n_trig - b_trig, 32'd2);
        end
        rd(STC_OFS_STATUS, 16'h0001);
        rd(STC_OFS_CTRL, ctl | 16'h1000);
        @(negedge sys_clk);
        check(32'(irq), 32'd1);
        bus(1'b1, STC_OFS_CTRL, ctl & 16'hf7ff);
        @(negedge sys_clk);
        check(32'(irq), 32'd0);
        bus(1'b1, STC_OFS_STATUS, 16'h0001);
        rd(STC_OFS_CTRL, ctl & 16'h07ff);
        // period kept above any external sync period used here
        bus(1'b1, STC_OFS_CTRL, 16'h0000);
        bus(1'b1, STC_OFS_PERIOD, per);
        rd(STC_OFS_ACT_PERIOD, 16'hffff);
        u_far.fire(0);
        rd(STC_OFS_ACT_PERIOD, per);
        @(negedge sys_clk);
        check(32'(act_per), 32'(per));
        bus(1'b1, STC_OFS_CTRL, 16'h0400);
        bus(1'b1, STC_OFS_PERIOD, 16'h0567);
        rd(STC_OFS_ACT_PERIOD, 16'h0567);
        // upper byte lane only: the low byte of the period must survive
        be_sel = 4'h2;
        bus(1'b1, STC_OFS_PERIOD, 16'hab99);
        be_sel = 4'h3;
        rd(STC_OFS_ACT_PERIOD, 16'hab67);
        @(negedge sys_clk);
        check(32'(act_per), 32'h0000_ab67);
        check(n_load, 32'd3);
        rd(STC_OFS_STATUS, 16'h0004);
        // polarity changes only while sync is off, so no false edge reaches the block
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, STC_OFS_CTRL, sy[i] & 16'h0200);
            far_pol <= sy[i][9];
            repeat (4) @(posedge sys_clk);
            bus(1'b1, STC_OFS_CTRL, sy[i]);
            repeat (2) @(posedge sys_clk);
            snap();
            u_far.fire(2);
            u_far.fire(3);
            u_far.fire(0);
            repeat (6) @(posedge sys_clk);
            @(negedge sys_clk);
            check(32'(sout_oe), 32'(sy[i][8]));
            check(n_ext - b_ext, sy_ext[i]);
            check(n_out - b_out, 32'(sy[i][8]));
        end
        rd(STC_OFS_STATUS, 16'h0006);
        bus(1'b1, STC_OFS_MASK, 16'h0002);
        @(negedge sys_clk);
        check(32'(irq), 32'd1);
        finish_test();
    end
endmodule
